// *** speed_pkg.sv ***
// Constants shared by the spindle speed discriminator.
// Assumes a single 10 MHz system clock and synchronous pin inputs.
package speed_pkg;
    localparam int unsigned CLOCK_HZ = 10000000;
    localparam int unsigned COUNT_W = 12;
    localparam logic [11:0] COUNT_HIGH = 12'h56c;
    localparam logic [11:0] COUNT_LOW = 12'h682;
    localparam int unsigned RPM_SCALE = 60;
    localparam int unsigned LOCK_HZ_HIGH = 360;
    localparam int unsigned LOCK_HZ_LOW = 300;
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [1:0] RESET_SYNC_INIT = 2'h0;
    localparam logic [11:0] COUNT_RESET = 12'h000;

    typedef enum logic [1:0] {
        ERR_IDLE = 2'b00,
        ERR_SLOW = 2'b01,
        ERR_FAST = 2'b10
    } err_state_e;
endpackage

// *** spindle_speed_discriminator.sv ***
// Digital speed servo core: reference divider, tach period discriminator,
// standby control and thermal shutdown gating.
// Assumes osc_clock_in is a synchronous enable-free level on clock and that
// tach_pulse_out and the over-temperature flag are synchronous levels.
//
// Contract
// - Reference clock is oscillator divided by two.
// - Tach input is a rectangular pulse train.
// - Count reference ticks, pulse error by difference.
// - Count 1388 when select high, else 1666.
// - Speed equals 60 fref over 2n over z.
// - Run low operates, run high is standby.
// - Bias switch open in standby, closed running.
// - Shut down at 170 C, restore at 140 C.
// - Lock tach at 360 Hz high, 300 Hz low.
module spindle_speed_discriminator
    import speed_pkg::*;
#(
    parameter int unsigned TOOTH_NUMBER = 1
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic osc_clock_in,
    input wire logic tach_pulse_out,
    input wire logic speed_select,
    input wire logic run_standby_ctrl,
    input wire logic temp_hot_170,
    input wire logic temp_cool_140,
    output logic osc_clock_out,
    output logic ref_clock,
    output logic bias_switch_on,
    output logic drive_enable,
    output logic discriminator_error_out,
    output logic discriminator_error_oe,
    output logic [COUNT_W-1:0] last_period
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= RESET_SYNC_INIT;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------
    // Standby and thermal shutdown
    // ----------------------------------------------------------------
    logic hot_q;
    logic active;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hot_q <= 1'b0;
        end else if (temp_hot_170) begin
            hot_q <= 1'b1;
        end else if (temp_cool_140) begin
            hot_q <= 1'b0;
        end
    end

    assign active = !run_standby_ctrl && !hot_q;
    assign bias_switch_on = active;
    assign drive_enable = active;
    assign osc_clock_out = !osc_clock_in;

    // ----------------------------------------------------------------
    // Reference divider
    // ----------------------------------------------------------------
    logic osc_d1_q;
    logic ref_q;
    logic ref_tick;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_d1_q <= 1'b0;
            ref_q <= 1'b0;
        end else begin
            osc_d1_q <= osc_clock_in;
            if (osc_clock_in && !osc_d1_q) begin
                ref_q <= !ref_q;
            end
        end
    end
    assign ref_tick = osc_clock_in && !osc_d1_q && ref_q;
    assign ref_clock = ref_q;

    // ----------------------------------------------------------------
    // Tach synchroniser
    // ----------------------------------------------------------------
    logic [SYNC_STAGES-1:0] tach_sync_q;
    logic tach_prev_q;
    logic tach_rise;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tach_sync_q <= '0;
            tach_prev_q <= 1'b0;
        end else begin
            tach_sync_q <= {tach_sync_q[0], tach_pulse_out};
            tach_prev_q <= tach_sync_q[1];
        end
    end
    // rising edge marks one tach period
    assign tach_rise = tach_sync_q[1] && !tach_prev_q;

    // ----------------------------------------------------------------
    // Discriminator
    // ----------------------------------------------------------------
    function automatic logic [COUNT_W-1:0] target(input logic sel);
        return sel ? COUNT_HIGH : COUNT_LOW;
    endfunction

    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    logic [COUNT_W-1:0] err_len_q;
    logic [COUNT_W-1:0] goal;
    err_state_e err_q;
    logic at_goal;

    // target is half the count in oscillator periods
    assign goal = target(speed_select);
    // Saturate at or above the goal, so that a switch to the shorter count
    // in mid-period holds the counter instead of letting it wrap.
    assign at_goal = (count_q >= goal);
    assign count_d = count_q + 12'h001;

    // measure tach period in reference ticks
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= COUNT_RESET;
            last_period <= COUNT_RESET;
        end else if (!active) begin
            count_q <= COUNT_RESET;
        end else if (tach_rise) begin
            count_q <= COUNT_RESET;
            last_period <= count_q;
        end else if (ref_tick && !at_goal) begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            err_q <= ERR_IDLE;
            err_len_q <= COUNT_RESET;
        end else if (!active) begin
            err_q <= ERR_IDLE;
            err_len_q <= COUNT_RESET;
        end else if (tach_rise) begin
            if (count_q < goal) begin
                err_q <= ERR_FAST;
                err_len_q <= 12'(goal - count_q);
            end else begin
                err_q <= ERR_IDLE;
                err_len_q <= COUNT_RESET;
            end
        end else if (ref_tick && at_goal) begin
            err_q <= ERR_SLOW;
            err_len_q <= 12'h001;
        end else if (ref_tick && err_len_q != COUNT_RESET) begin
            err_len_q <= err_len_q - 12'h001;
            if (err_len_q == 12'h001 && err_q == ERR_FAST) begin
                err_q <= ERR_IDLE;
            end
        end
    end

    always_comb begin
        case (err_q)
            ERR_FAST: begin
                discriminator_error_out = 1'b0;
                discriminator_error_oe = 1'b1;
            end
            ERR_SLOW: begin
                discriminator_error_out = 1'b1;
                discriminator_error_oe = 1'b1;
            end
            default: begin
                discriminator_error_out = 1'b0;
                discriminator_error_oe = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_short_period;
        active && tach_rise && count_q < goal;
    endsequence
    sequence s_decelerate;
        discriminator_error_oe && !discriminator_error_out;
    endsequence

    a_standby_bias: assert property (
        @(posedge clock) disable iff (!rst_n)
        run_standby_ctrl |-> !bias_switch_on)
        else $error("bias on in standby");
    a_standby_count: assert property (
        @(posedge clock) disable iff (!rst_n)
        !active |=> count_q == COUNT_RESET)
        else $error("counter not cleared in standby");
    a_hot_off: assert property (
        @(posedge clock) disable iff (!rst_n)
        temp_hot_170 |=> !drive_enable)
        else $error("drive on while hot");
    a_fast_drive: assert property (
        @(posedge clock) disable iff (!rst_n)
        s_short_period |=> s_decelerate)
        else $error("no decelerate on short period");
    a_slow_drive: assert property (
        @(posedge clock) disable iff (!rst_n)
        active && !tach_rise && ref_tick && at_goal |=>
        discriminator_error_out)
        else $error("no accelerate on long period");
    a_ref_half: assert property (
        @(posedge clock) disable iff (!rst_n)
        osc_clock_in && !osc_d1_q |=> ref_q != $past(ref_q))
        else $error("reference not toggled");
    a_goal_sel: assert property (
        @(posedge clock) disable iff (!rst_n)
        goal == (speed_select ? COUNT_HIGH : COUNT_LOW))
        else $error("wrong discriminator count");
    a_count_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        active && !tach_rise && count_q >= goal |=>
        count_q == $past(count_q))
        else $error("counter not held at goal");
    a_run_active: assert property (
        @(posedge clock) disable iff (!rst_n)
        !run_standby_ctrl && !hot_q |-> drive_enable)
        else $error("not operational with run low");
endmodule

// *** motor_model.sv ***
// Spindle tach and error integrator model.
// Assumes one clock; the bench sets the tach half period in cycles.
module motor_model (
    input wire logic clock,
    input wire integer half,
    input wire logic err,
    input wire logic oe,
    output logic osc,
    output logic tach,
    output int level
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial begin
        osc = 1'b0;
        tach = 1'b0;
        level = 0;
    end
    always @(posedge clock) begin
        osc <= ~osc;
        cnt <= (cnt >= half - 1) ? 0 : cnt + 1;
        if (cnt >= half - 1) tach <= ~tach;
        if (oe) level <= err ? level + 1 : level - 1;
    end
endmodule

// *** tb.sv ***
// Self-checking bench for the spindle speed discriminator.
// Assumes the motor model supplies the oscillator and tach waves.
module tb;
    import speed_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, nrst = 1'b0, sel = 1'b1, stby = 1'b0;
    logic hot = 1'b0, cool = 1'b1, osc, tach, osc_o, rclk, bias, drv;
    logic err, oe;
    logic [COUNT_W-1:0] per;
    int half = 4000, level, lv, bad_count = 0, check_count = 0, cyc = 0;
    spindle_speed_discriminator DUT (.clock(clock), .nrst(nrst),
        .osc_clock_in(osc), .tach_pulse_out(tach), .speed_select(sel),
        .run_standby_ctrl(stby), .temp_hot_170(hot),
        .temp_cool_140(cool), .osc_clock_out(osc_o), .ref_clock(rclk),
        .bias_switch_on(bias), .drive_enable(drv),
        .discriminator_error_out(err), .discriminator_error_oe(oe),
        .last_period(per));
    motor_model m (.clock(clock), .half(half), .err(err), .oe(oe),
        .osc(osc), .tach(tach), .level(level));
    initial forever #50 clock = ~clock;
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // A hung wait on the tach ends here as a mismatch.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic cmp1(string what, logic exp, logic got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s exp %b got %b", what, exp, got);
        end
    endtask
    task automatic cmp12(string what, logic [11:0] exp, logic [11:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_osc;
        int n;
        logic p;
        n = 0;
        p = rclk;
        repeat (80) begin
            @(posedge clock);
            #1;
            if (rclk === 1'b1 && p === 1'b0) n++;
            p = rclk;
        end
        cmp1("osc_out", ~osc, osc_o);
        cmp1("ref_rate", 1'b1, n >= 19 && n <= 21);
        $display("t_osc done");
    endtask
    task automatic t_goal(logic s, logic [11:0] g);
        @(posedge clock);
        sel <= s;
        half <= 4000;
        @(posedge tach);
        @(posedge tach);
        repeat (7000) @(posedge clock);
        #1;
        lv = level;
        cmp12("period", g, per);
        cmp1("oe", 1'b1, oe);
        cmp1("err", 1'b1, err);
        repeat (100) @(posedge clock);
        #1;
        cmp1("integ_up", 1'b1, level > lv);
        $display("t_goal done");
    endtask
    task automatic t_short;
        logic f;
        f = 1'b0;
        @(posedge clock);
        half <= 200;
        repeat (1500) @(posedge clock);
        lv = level;
        repeat (400) begin
            @(posedge clock);
            #1;
            if (oe === 1'b1 && err === 1'b0) f = 1'b1;
        end
        cmp1("fast", 1'b1, f);
        cmp1("integ_dn", 1'b1, level < lv);
        cmp1("count", 1'b1, per >= 99 && per <= 101);
        $display("t_short done");
    endtask
    task automatic t_near;
        @(posedge clock);
        half <= 3200;
        @(posedge tach);
        @(posedge tach);
        repeat (100) @(posedge clock);
        #1;
        cmp1("near_oe", 1'b1, oe);
        cmp1("near_err", 1'b0, err);
        repeat (400) @(posedge clock);
        #1;
        cmp1("pulse_end", 1'b0, oe);
        cmp1("near_per", 1'b1, per >= 1599 && per <= 1600);
        $display("t_near done");
    endtask
    task automatic t_pin(logic s, logic h, logic c, logic e);
        @(posedge clock);
        stby <= s;
        hot <= h;
        cool <= c;
        repeat (3) @(posedge clock);
        #1;
        cmp1("bias", e, bias);
        cmp1("drive", e, drv);
        if (!e) cmp1("oe", 1'b0, oe);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        t_osc();
        t_goal(1'b1, COUNT_HIGH);
        t_goal(1'b0, COUNT_LOW);
        t_short();
        t_near();
        t_pin(1'b1, 1'b0, 1'b1, 1'b0);
        t_pin(1'b0, 1'b0, 1'b1, 1'b1);
        $display("t_standby done");
        t_pin(1'b0, 1'b1, 1'b1, 1'b0);
        t_pin(1'b0, 1'b1, 1'b0, 1'b0);
        t_pin(1'b0, 1'b0, 1'b0, 1'b0);
        t_pin(1'b0, 1'b0, 1'b1, 1'b1);
        $display("t_thermal done");
        finish_test();
    end
endmodule
